// ---- inc/lpmc_defines.svh ----
`ifndef LPMC_DEFINES_SVH
`define LPMC_DEFINES_SVH

// Register byte addresses on the Wishbone bus
`define LPMC_ADDR_MODE 4'h0
`define LPMC_ADDR_WAKE 4'h4
`define LPMC_ADDR_STAT 4'h8
`define LPMC_ADDR_W 4

// Mode control fields
`define LPMC_SEL_LO 0
`define LPMC_SEL_HI 1
`define LPMC_QUAL_LO 2
`define LPMC_QUAL_HI 7
`define LPMC_MODE_WMASK 16'h00FF
`define LPMC_MODE_RST 16'h0000
`define LPMC_WAKE_RST 16'h0000

// Mode select encodings
`define LPMC_SEL_IDLE 2'h0
`define LPMC_SEL_STBY 2'h1

// Qualification count is field plus this offset
`define LPMC_QUAL_BASE 7'h02

// Wake enable bit of the non-maskable input
`define LPMC_WAKE_NMI 1

// Status register bit positions
`define LPMC_ST_STATE_LO 0
`define LPMC_ST_STATE_HI 1
`define LPMC_ST_WAKE 2

`endif

// ---- inc/lpmc_pkg.sv ----
`default_nettype none
package lpmc_pkg;
	typedef enum logic [1:0] {
		LPMC_RUN,
		LPMC_IDLE,
		LPMC_STANDBY,
		LPMC_HALT
	} lpmc_state_type;
endpackage
`default_nettype wire

// ---- inc/lpmc_qual_if.sv ----
`default_nettype none
interface lpmc_qual_if;
	logic restart;
	logic active_low;
	logic [5:0] count_field;
	logic qualified;
	modport ctrl (output restart, output active_low, output count_field,
		input qualified);
	modport qual (input restart, input active_low, input count_field,
		output qualified);
endinterface
`default_nettype wire

// ---- core/lpmc_wake_qual.sv ----
`default_nettype none
`include "lpmc_defines.svh"
module lpmc_wake_qual
	import lpmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	lpmc_qual_if.qual q
);
	logic [6:0] count_reg;
	logic [6:0] count_next;
	logic qualified_reg;
	logic qualified_next;
	logic [6:0] target;

	always_comb begin
		target = {1'b0, q.count_field} + `LPMC_QUAL_BASE;
		count_next = count_reg;
		qualified_next = 1'b0;
		if (q.restart || !q.active_low) begin
			count_next = 7'h00;
		end else if (count_reg != target) begin
			count_next = count_reg + 7'h01;
		end
		if (!q.restart && q.active_low && count_next == target) begin
			qualified_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= 7'h00;
			qualified_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			qualified_reg <= qualified_next;
		end
	end

	assign q.qualified = qualified_reg;
endmodule // lpmc_wake_qual
`default_nettype wire

// ---- core/lpmc_top.sv ----
// Function
// - Two-bit mode select in low bits of mode control; resets to zero.
// - Mode select acts only at idle instruction; software sets it first.
// - Standby wake needs field value plus two oscillator cycles low.
// - Wake enable bit one lets its source wake standby; fixed bit map.
// - Sources with enable zero never end standby.
// - External reset clears mode control and wake enable registers.
// - Low level on enabled wake signal exits; short pulses do not.
// - Oscillator clock keeps running in standby to qualify wake signals.
// - Only reset and non-maskable input wake from halt.
// - Idle with select zero performs no low-power action.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`default_nettype none
`include "lpmc_defines.svh"
module lpmc_top
	import lpmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic idle_exec_i,
	input wire logic [15:0] wake_n_i,
	output logic standby_o,
	output logic halt_o,
	output logic osc_enable_o,
	output logic wake_o
);
	lpmc_qual_if qif ();

	lpmc_state_type state_reg;
	lpmc_state_type state_next;
	logic [15:0] mode_reg;
	logic [15:0] mode_next;
	logic [15:0] wake_en_reg;
	logic [15:0] wake_en_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;
	logic ack_reg;
	logic ack_next;
	logic standby_reg;
	logic standby_next;
	logic halt_reg;
	logic halt_next;
	logic osc_reg;
	logic osc_next;
	logic wake_reg;
	logic wake_next;
	logic any_low;
	logic [15:0] masked_low;
	logic access;

	// Merge the two low byte lanes of a write into a 16-bit register
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] sel,
		input logic [15:0] wmask);
		logic [15:0] res;
		res = old;
		if (sel[0]) begin
			res[7:0] = data[7:0];
		end
		if (sel[1]) begin
			res[15:8] = data[15:8];
		end
		lane_merge = (res & wmask) | (old & ~wmask);
	endfunction

	// Decode the select field into the state entered at the idle instruction
	function automatic lpmc_state_type mode_target(input logic [1:0] sel);
		lpmc_state_type res;
		res = LPMC_IDLE;
		case (sel)
			`LPMC_SEL_IDLE: begin
				res = LPMC_IDLE;
			end
			`LPMC_SEL_STBY: begin
				res = LPMC_STANDBY;
			end
			default: begin
				// Both codes with the high bit set select halt
				res = LPMC_HALT;
			end
		endcase
		mode_target = res;
	endfunction

	// Ack drops the cycle after it is given, even if strobe stays high
	assign access = wb_cyc_i && wb_stb_i && !ack_reg;

	// Register slave; upper half and unmapped addresses read zero
	always_comb begin
		mode_next = mode_reg;
		wake_en_next = wake_en_reg;
		dat_next = dat_reg;
		ack_next = access;
		if (access) begin
			dat_next = 32'h0000_0000;
			case (wb_adr_i)
				`LPMC_ADDR_MODE: begin
					if (wb_we_i) begin
						mode_next = lane_merge(mode_reg, wb_dat_i, wb_sel_i,
							`LPMC_MODE_WMASK);
					end
					dat_next[15:0] = mode_reg;
				end
				`LPMC_ADDR_WAKE: begin
					if (wb_we_i) begin
						wake_en_next = lane_merge(wake_en_reg, wb_dat_i,
							wb_sel_i, 16'hFFFF);
					end
					dat_next[15:0] = wake_en_reg;
				end
				`LPMC_ADDR_STAT: begin
					dat_next[`LPMC_ST_STATE_HI:`LPMC_ST_STATE_LO] = state_reg;
					dat_next[`LPMC_ST_WAKE] = wake_reg;
				end
				default: begin
					dat_next = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= `LPMC_MODE_RST;
			wake_en_reg <= `LPMC_WAKE_RST;
			dat_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			wake_en_reg <= wake_en_next;
			dat_reg <= dat_next;
			ack_reg <= ack_next;
		end
	end

	// Disabled sources are masked before they reach the qualifier
	assign masked_low = ~wake_n_i & wake_en_reg;
	assign any_low = |masked_low;

	// Restart outside standby so a stale count never carries into a new entry
	assign qif.restart = (state_reg != LPMC_STANDBY);
	assign qif.active_low = any_low;
	assign qif.count_field = mode_reg[`LPMC_QUAL_HI:`LPMC_QUAL_LO];

	lpmc_wake_qual u_qual (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.q(qif.qual)
	);

	// Mode sequencer; halt skips qualification since the oscillator stops
	always_comb begin
		state_next = state_reg;
		wake_next = 1'b0;
		case (state_reg)
			LPMC_RUN: begin
				// Select is sampled only here, so later writes wait for next idle
				if (idle_exec_i) begin
					state_next = mode_target(
						mode_reg[`LPMC_SEL_HI:`LPMC_SEL_LO]);
				end
			end
			LPMC_IDLE: begin
				// Core leaves plain idle on its own interrupts
				if (!idle_exec_i) begin
					state_next = LPMC_RUN;
				end
			end
			LPMC_STANDBY: begin
				if (qif.qualified) begin
					state_next = LPMC_RUN;
					wake_next = 1'b1;
				end
			end
			LPMC_HALT: begin
				if (!wake_n_i[`LPMC_WAKE_NMI]) begin
					state_next = LPMC_RUN;
					wake_next = 1'b1;
				end
			end
			default: begin
				state_next = LPMC_RUN;
			end
		endcase
		standby_next = (state_next == LPMC_STANDBY);
		halt_next = (state_next == LPMC_HALT);
		osc_next = (state_next != LPMC_HALT);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= LPMC_RUN;
			wake_reg <= 1'b0;
			standby_reg <= 1'b0;
			halt_reg <= 1'b0;
			osc_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			wake_reg <= wake_next;
			standby_reg <= standby_next;
			halt_reg <= halt_next;
			osc_reg <= osc_next;
		end
	end


	// Every output comes straight from a register
	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign standby_o = standby_reg;
	assign halt_o = halt_reg;
	assign osc_enable_o = osc_reg;
	assign wake_o = wake_reg;
endmodule // lpmc_top
`default_nettype wire

// ---- verif/lpmc_asserts.sv ----
`default_nettype none
module lpmc_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic idle_exec_i,
	input wire logic [15:0] wake_n_i,
	input wire logic standby_o,
	input wire logic halt_o,
	input wire logic osc_enable_o,
	input wire logic wake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack long");
	property p_sb; $rose(standby_o) |-> $past(idle_exec_i); endproperty
	a_sb: assert property (p_sb) else $error("standby uncaused");
	property p_hl; $rose(halt_o) |-> $past(idle_exec_i); endproperty
	a_hl: assert property (p_hl) else $error("halt uncaused");
	property p_osc; !osc_enable_o |-> halt_o; endproperty
	a_osc: assert property (p_osc) else $error("osc stopped");
	property p_nmi; halt_o && !wake_n_i[1] |-> ##[1:2] !halt_o; endproperty
	a_nmi: assert property (p_nmi) else $error("halt stuck");
	property p_hh; halt_o && wake_n_i[1] && $past(wake_n_i[1]) |=> halt_o;
	endproperty
	a_hh: assert property (p_hh) else $error("halt left");
	// Six quiet cycles cover the worst qualification pipeline
	property p_qt; (standby_o && wake_n_i == 16'hFFFF)[*6] |=> standby_o;
	endproperty
	a_qt: assert property (p_qt) else $error("standby left");
	property p_wk; wake_o |=> !wake_o; endproperty
	a_wk: assert property (p_wk) else $error("wake long");
	c_sb: cover property ($rose(standby_o));
	c_hl: cover property ($rose(halt_o));
	c_wk: cover property (wake_o);
endmodule // lpmc_asserts
`default_nettype wire

// ---- verif/lpmc_core_model.sv ----
`default_nettype none
module lpmc_core_model (
	input wire logic clk_i,
	input wire logic idle_req_i,
	input wire logic [15:0] wake_req_i,
	output var logic idle_exec_o,
	output var logic [15:0] wake_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle only after software has set the mode
	always_ff @(posedge clk_i) idle_exec_o <= idle_req_i;
	// Sources are active low levels
	always_ff @(posedge clk_i) wake_n_o <= ~wake_req_i;
endmodule // lpmc_core_model
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ir = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0, q, dat_o;
	logic [15:0] wr = 16'h0, wn;
	logic ack, idle, sb, hl, osc, wk;
	int n_fail = 0, n_tests = 0, t = 0;
	lpmc_top dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .idle_exec_i(idle),
		.wake_n_i(wn), .standby_o(sb), .halt_o(hl), .osc_enable_o(osc),
		.wake_o(wk));
	lpmc_core_model core (.clk_i, .idle_req_i(ir), .wake_req_i(wr),
		.idle_exec_o(idle), .wake_n_o(wn));
	task automatic chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wb(input logic [3:0] a, input logic w, input logic [15:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {16'h0000, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
	endtask
	task automatic enter(input logic [15:0] mode, en);
		wb(4'h0, 1'b1, mode);
		wb(4'h4, 1'b1, en);
		ir <= 1'b1;
		@(posedge clk_i);
		ir <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	// Latency counts from the bench request: N plus model, qualifier, wake
	task automatic wake_chk(input logic [15:0] r, input int e);
		int n;
		n = 0;
		wr <= r;
		do begin
			@(posedge clk_i);
			n++;
		end while (wk !== 1'b1 && n < 200);
		wr <= 16'h0000;
		chk(n >= e - 1 && n <= e + 1, 1);
	endtask
	initial forever #50 clk_i = ~clk_i;
	always @(posedge clk_i) if (++t == 5000) begin
		n_fail++;
		end_sim;
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(4'h0, 1'b0, 16'h0);
		chk(q, 32'h0);
		wb(4'hC, 1'b0, 16'h0);
		chk(q, 32'h0);
		wb(4'h0, 1'b1, 16'hFFFF);
		wb(4'h0, 1'b0, 16'h0);
		chk(q, 32'hFF);
		for (int i = 0; i < 16; i++) begin
			enter({8'h00, (i == 15) ? 6'h3F : 6'h00, 2'h1}, 16'h1 << i);
			chk(sb, 1'b1);
			wake_chk(16'h1 << i, (i == 15) ? 68 : 5);
			@(posedge clk_i);
			chk(sb, 1'b0);
		end
		enter(16'h0005, 16'h0001);
		wr <= 16'hFFFE;
		repeat (12) @(posedge clk_i);
		wr <= 16'h0001;
		repeat (2) @(posedge clk_i);
		wr <= 16'h0000;
		repeat (8) @(posedge clk_i);
		chk(sb, 1'b1);
		wake_chk(16'h0001, 6);
		enter(16'h0002, 16'h0001);
		chk({hl, osc}, 2'b10);
		wr <= 16'h0001;
		repeat (8) @(posedge clk_i);
		chk(hl, 1'b1);
		wb(4'h8, 1'b0, 16'h0);
		chk(q, 32'h3);
		wake_chk(16'h0002, 3);
		enter(16'h0000, 16'hFFFF);
		chk({sb, hl, osc}, 3'b001);
		wb(4'h4, 1'b0, 16'h0);
		chk(q, 32'hFFFF);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		wb(4'h4, 1'b0, 16'h0);
		chk(q, 32'h0);
		end_sim;
	end
endmodule // tb
bind lpmc_top lpmc_asserts chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .idle_exec_i, .wake_n_i, .standby_o, .halt_o,
	.osc_enable_o, .wake_o);
`default_nettype wire
